/* File: verilog/icsc_regs.svh */
// Register indices, field positions, port addresses and reset values
`ifndef ICSC_REGS_SVH
`define ICSC_REGS_SVH

`define ICSC_PORT_MONO_IDX    16'h03b4
`define ICSC_PORT_COLOR_IDX   16'h03d4
`define ICSC_PORT_DATA_OFS    16'h0001

`define ICSC_IDX_INTERLACE    8'h70
`define ICSC_IDX_VIDEO_OUT    8'h71
`define ICSC_IDX_SERR_ONE     8'h72
`define ICSC_IDX_SERR_TWO     8'h73
`define ICSC_IDX_EQU_WIDTH    8'h74

`define ICSC_RST_BYTE         8'h00
`define ICSC_RST_EQU          6'h00

`define ICSC_BIT_ILACE_EN     7
`define ICSC_HALF_HI          6
`define ICSC_HALF_LO          0
`define ICSC_BIT_PAL_SEL      7
`define ICSC_BIT_PEDESTAL     6
`define ICSC_BIT_BLANK_DLY    5
`define ICSC_CHAR_DLY_HI      4
`define ICSC_CHAR_DLY_LO      3
`define ICSC_PIX_DLY_HI       2
`define ICSC_PIX_DLY_LO       0
`define ICSC_BIT_EQU_OFF      5
`define ICSC_EQU_W_HI         4
`define ICSC_EQU_W_LO         0

`define ICSC_CHAR_TAPS        4
`define ICSC_PIX_TAPS         8
`define ICSC_EQU_ONE          5'h01

`endif

/* File: verilog/icsc_pkg.sv */
// Types shared by the interlace and composite sync control block
`default_nettype none

package icsc_pkg;

  typedef enum logic [0:0] {
    ICSC_EQU_IDLE = 1'b0,
    ICSC_EQU_HIGH = 1'b1
  } icsc_equ_state_t;

  typedef logic [7:0] icsc_byte_t;

endpackage

`default_nettype wire

/* File: verilog/icsc_dly_if.sv */
// Carrier between the control block and the composite sync delay line
`timescale 1ns/10ps
`default_nettype none

interface icsc_dly_if;
  logic       csync_in;
  logic       char_tick;
  logic [1:0] char_sel;
  logic [2:0] pix_sel;
  logic       csync_out;

  modport ctrl (
    output csync_in,
    output char_tick,
    output char_sel,
    output pix_sel,
    input  csync_out
  );

  modport dly (
    input  csync_in,
    input  char_tick,
    input  char_sel,
    input  pix_sel,
    output csync_out
  );
endinterface

`default_nettype wire

/* File: verilog/icsc_delay.sv */
// Composite sync delay line: character clock stage then pixel clock stage
`timescale 1ns/10ps
`default_nettype none
`include "icsc_regs.svh"

module icsc_delay
  import icsc_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  icsc_dly_if.dly   dif
);

  wire logic [`ICSC_CHAR_TAPS-1:0] char_w;
  wire logic [`ICSC_PIX_TAPS-1:0]  pix_w;
  logic                            out_q;

  assign char_w[0] = dif.csync_in;
  assign pix_w[0]  = char_w[dif.char_sel]; // R7

  // Each stage owns its flop, so no vector has two kinds of driver
  genvar g;
  generate
    for (g = 1; g < `ICSC_CHAR_TAPS; g++)
    begin : g_char
      logic stage_q;
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          stage_q <= 1'b0;
        else if (dif.char_tick)
          stage_q <= char_w[g-1];
      end
      assign char_w[g] = stage_q;
    end
    for (g = 1; g < `ICSC_PIX_TAPS; g++)
    begin : g_pix
      logic stage_q;
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          stage_q <= 1'b0;
        else
          stage_q <= pix_w[g-1];
      end
      assign pix_w[g] = stage_q;
    end
  endgenerate

  // Output flop adds one fixed pixel clock to every setting
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_q <= 1'b0;
    else
      out_q <= pix_w[dif.pix_sel]; // R8
  end

  assign dif.csync_out = out_q;

endmodule

`default_nettype wire

/* File: verilog/icsc_top.sv */
// Interlace and composite sync control with indexed I/O register pair
// Overview of operation
// R1 - Interlace bit 7: 0 progressive, reset 0
// R2 - Bits 6-0 place odd-frame half-line vsync
// R3 - Odd vsync starts mid-line on last line
// R4 - Bit 7 selects NTSC or PAL format
// R5 - Pedestal only during active video when enabled
// R6 - Odd-frame blanking delayed half line if set
// R7 - Composite sync delayed 0-3 character clocks
// R8 - Composite sync delayed 0-7 pixel clocks
// R9 - First serration start position, eight bits
// R10 - Second serration start position, eight bits
// R11 - Bit 5 set suppresses equalization pulses
// R12 - Software loads width field as width minus one
// R13 - Width is (field minus roundoff)/2 plus one
// R14 - Index port then data port access
// R15 - Reserved width bits read zero
`timescale 1ns/10ps
`default_nettype none
`include "icsc_regs.svh"

module icsc_top
  import icsc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_color_sel,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_claim,
  input  wire logic        i_char_tick,
  input  wire logic [7:0]  i_hpos,
  input  wire logic        i_hsync,
  input  wire logic        i_vsync,
  input  wire logic        i_last_line,
  input  wire logic        i_odd_frame,
  input  wire logic        i_active,
  input  wire logic        i_blank,
  input  wire logic        i_equ_window,
  input  wire logic        i_csync,
  output logic             o_interlace,
  output logic             o_pal_sel,
  output logic             o_half_vsync,
  output logic             o_pedestal,
  output logic             o_blank,
  output logic             o_serration,
  output logic             o_equ_pulse,
  output logic             o_csync
);

  logic            rst_s1_q;
  logic            rst_n_q;
  icsc_byte_t      index_q;
  icsc_byte_t      ilace_q;
  icsc_byte_t      vout_q;
  icsc_byte_t      serr1_q;
  icsc_byte_t      serr2_q;
  logic [5:0]      equ_q;
  icsc_byte_t      rdata_q;
  logic            half_q;
  logic            ped_q;
  logic            blank_q;
  logic            serr_q;
  logic            hsync_q;
  logic [4:0]      equ_cnt_q;
  icsc_equ_state_t equ_st_q;
  icsc_equ_state_t equ_st_d;
  logic [15:0]     idx_port;
  logic            wr_idx;
  logic            wr_dat;
  logic            rd_idx;
  logic            rd_dat;
  logic            odd_dly;
  logic            half_hit;
  logic            hs_rise;
  logic [4:0]      equ_width;
  icsc_byte_t      rd_mux;

  icsc_dly_if dif ();

  // Reset release through two flops
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  function automatic logic port_hit(input logic [15:0] a,
                                    input logic [15:0] p);
    port_hit = (a == p);
  endfunction

  // Mono or color address pair, chosen like the other CRT registers
  assign idx_port = i_color_sel ? `ICSC_PORT_COLOR_IDX : `ICSC_PORT_MONO_IDX;
  assign wr_idx = i_io_wr && port_hit(i_io_addr, idx_port); // R14
  assign wr_dat = i_io_wr &&
                  port_hit(i_io_addr, idx_port + `ICSC_PORT_DATA_OFS); // R14
  assign rd_idx = i_io_rd && port_hit(i_io_addr, idx_port);
  assign rd_dat = i_io_rd &&
                  port_hit(i_io_addr, idx_port + `ICSC_PORT_DATA_OFS);
  assign o_io_claim = (i_io_rd || i_io_wr) &&
                      (port_hit(i_io_addr, idx_port) ||
                       port_hit(i_io_addr, idx_port + `ICSC_PORT_DATA_OFS));

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      index_q <= `ICSC_RST_BYTE;
    else if (wr_idx)
      index_q <= i_io_wdata; // R14
  end

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ilace_q <= `ICSC_RST_BYTE; // R1
      vout_q  <= `ICSC_RST_BYTE;
      serr1_q <= `ICSC_RST_BYTE;
      serr2_q <= `ICSC_RST_BYTE;
      equ_q   <= `ICSC_RST_EQU;
    end
    else if (wr_dat)
    begin
      case (index_q)
        `ICSC_IDX_INTERLACE: ilace_q <= i_io_wdata;
        `ICSC_IDX_VIDEO_OUT: vout_q  <= i_io_wdata;
        `ICSC_IDX_SERR_ONE:  serr1_q <= i_io_wdata; // R9
        `ICSC_IDX_SERR_TWO:  serr2_q <= i_io_wdata; // R10
        `ICSC_IDX_EQU_WIDTH: equ_q   <= i_io_wdata[5:0]; // R15
        default:             ;
      endcase
    end
  end

  always_comb
  begin
    case (index_q)
      `ICSC_IDX_INTERLACE: rd_mux = ilace_q;
      `ICSC_IDX_VIDEO_OUT: rd_mux = vout_q;
      `ICSC_IDX_SERR_ONE:  rd_mux = serr1_q;
      `ICSC_IDX_SERR_TWO:  rd_mux = serr2_q;
      `ICSC_IDX_EQU_WIDTH: rd_mux = {2'h0, equ_q}; // R15
      default:             rd_mux = `ICSC_RST_BYTE;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= `ICSC_RST_BYTE;
    else if (rd_idx)
      rdata_q <= index_q;
    else if (rd_dat)
      rdata_q <= rd_mux; // R14
  end

  assign o_io_rdata  = rdata_q;
  assign o_interlace = ilace_q[`ICSC_BIT_ILACE_EN]; // R1
  assign o_pal_sel   = vout_q[`ICSC_BIT_PAL_SEL]; // R4

  assign half_hit = (i_hpos ==
                     {1'b0, ilace_q[`ICSC_HALF_HI:`ICSC_HALF_LO]}); // R2
  assign odd_dly  = o_interlace && i_odd_frame &&
                    vout_q[`ICSC_BIT_BLANK_DLY]; // R6

  // Mid-line vsync start on the odd frame's last line
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      half_q <= 1'b0;
    else
      half_q <= o_interlace && i_odd_frame && i_last_line &&
                half_hit && i_char_tick; // R3
  end

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ped_q <= 1'b0;
    else
      ped_q <= vout_q[`ICSC_BIT_PEDESTAL] && i_active; // R5
  end

  // Delayed blanking only picks up a change at the half-line point
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      blank_q <= 1'b0;
    else if (!odd_dly)
      blank_q <= i_blank;
    else if (half_hit && i_char_tick)
      blank_q <= i_blank; // R6
  end

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      serr_q <= 1'b0;
    else
      serr_q <= i_vsync && i_char_tick &&
                ((i_hpos == serr1_q) || (i_hpos == serr2_q)); // R9 R10
  end

  // Software writes width minus one; hardware halves it here
  assign equ_width = 5'((equ_q[`ICSC_EQU_W_HI:`ICSC_EQU_W_LO] -
                         {4'h0, equ_q[`ICSC_BIT_EQU_OFF]}) >> 1); // R13 R12
  assign hs_rise = i_hsync && !hsync_q;

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      hsync_q <= 1'b0;
    else
      hsync_q <= i_hsync;
  end

  always_comb
  begin
    equ_st_d = equ_st_q;
    case (equ_st_q)
      ICSC_EQU_IDLE:
        if (hs_rise && i_equ_window && !equ_q[`ICSC_BIT_EQU_OFF]) // R11
          equ_st_d = ICSC_EQU_HIGH;
      ICSC_EQU_HIGH:
        if (equ_cnt_q == `ICSC_EQU_ONE)
          equ_st_d = ICSC_EQU_IDLE;
      default:
        equ_st_d = ICSC_EQU_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      equ_st_q  <= ICSC_EQU_IDLE;
      equ_cnt_q <= 5'h00;
    end
    else
    begin
      equ_st_q <= equ_st_d;
      if (equ_st_q == ICSC_EQU_IDLE)
        equ_cnt_q <= 5'(equ_width + `ICSC_EQU_ONE); // R13
      else
        equ_cnt_q <= 5'(equ_cnt_q - `ICSC_EQU_ONE);
    end
  end

  assign o_half_vsync = half_q;
  assign o_pedestal   = ped_q;
  assign o_blank      = blank_q;
  assign o_serration  = serr_q;
  assign o_equ_pulse  = (equ_st_q == ICSC_EQU_HIGH);

  assign dif.csync_in  = i_csync;
  assign dif.char_tick = i_char_tick;
  assign dif.char_sel  = vout_q[`ICSC_CHAR_DLY_HI:`ICSC_CHAR_DLY_LO]; // R7
  assign dif.pix_sel   = vout_q[`ICSC_PIX_DLY_HI:`ICSC_PIX_DLY_LO]; // R8
  assign o_csync       = dif.csync_out;

  icsc_delay u_delay (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_q),
    .dif     (dif)
  );

endmodule

`default_nettype wire

/* File: verification/icsc_timing_model.sv */
// Line and frame timing source feeding the control block
`timescale 1ns/10ps
`default_nettype none

module icsc_timing_model
(
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  output logic            o_char_tick,
  output logic      [7:0] o_hpos,
  output logic            o_hsync,
  output logic            o_vsync,
  output logic            o_last_line,
  output logic            o_odd_frame,
  output logic            o_active,
  output logic            o_blank,
  output logic            o_equ_window
);
  logic [13:0] cnt_q;

  // 4 pixels a character, 128 characters a line, 16 lines a frame
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 14'h0001;

  assign o_char_tick  = &cnt_q[1:0];
  assign o_hpos       = {1'b0, cnt_q[8:2]};
  assign o_hsync      = o_hpos < 8'h08;
  assign o_vsync      = &cnt_q[12:10];
  assign o_last_line  = &cnt_q[12:9];
  assign o_odd_frame  = cnt_q[13];
  assign o_equ_window = &cnt_q[12:11];
  assign o_active     = !o_equ_window && o_hpos > 8'h0f;
  assign o_blank      = !o_active;
endmodule

`default_nettype wire

/* File: verification/icsc_top_asserts.sv */
// Port-level checks for the interlace and sync control block
`timescale 1ns/10ps
`default_nettype none
`include "icsc_regs.svh"

module icsc_top_asserts
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_color_sel,
  input wire logic [15:0] i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic        o_io_claim,
  input wire logic        i_char_tick,
  input wire logic [7:0]  i_hpos,
  input wire logic        i_hsync,
  input wire logic        i_vsync,
  input wire logic        i_last_line,
  input wire logic        i_odd_frame,
  input wire logic        i_active,
  input wire logic        i_blank,
  input wire logic        i_equ_window,
  input wire logic        o_interlace,
  input wire logic        o_half_vsync,
  input wire logic        o_pedestal,
  input wire logic        o_blank,
  input wire logic        o_serration,
  input wire logic        o_equ_pulse
);
  logic [2:0] rel_q;

  // Design holds its own reset copy two edges longer
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      rel_q <= '0;
    else
      rel_q <= {rel_q[1:0], 1'b1};

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!rel_q[2]);

  sequence s_hs_rise;
    $rose(i_hsync) && i_equ_window;
  endsequence
  sequence s_equ_rise;
    $rose(o_equ_pulse);
  endsequence

  a_ped_gate: assert property (o_pedestal |-> $past(i_active))
    else $error("pedestal outside active video");
  a_half_cause: assert property (o_half_vsync |->
    $past(o_interlace && i_odd_frame && i_last_line && i_char_tick))
    else $error("half-line sync without odd last line");
  a_half_pos: assert property (o_half_vsync |-> !$past(i_hpos[7]))
    else $error("half-line sync beyond seven-bit position");
  a_serr_vs: assert property (o_serration |->
    $past(i_vsync && i_char_tick))
    else $error("serration outside vertical sync");
  a_equ_cause: assert property (s_equ_rise |-> $past(i_hsync) &&
    !$past(i_hsync, 2) && $past(i_equ_window))
    else $error("equalization without sync rise");
  a_equ_len: assert property (s_equ_rise |-> ##[1:16] !o_equ_pulse)
    else $error("equalization pulse too long");
  a_blank_prog: assert property (!i_odd_frame |=>
    o_blank == $past(i_blank))
    else $error("blanking moved on even frame");
  a_claim_dec: assert property (o_io_claim == ((i_io_wr || i_io_rd) &&
    (i_io_addr & 16'hfffe) ==
    (i_color_sel ? `ICSC_PORT_COLOR_IDX : `ICSC_PORT_MONO_IDX)))
    else $error("port decode wrong");

  c_equ: cover property (s_hs_rise ##1 s_equ_rise);
endmodule

bind icsc_top icsc_top_asserts u_chk (
  .i_mclk, .i_nrst, .i_color_sel, .i_io_addr, .i_io_wr, .i_io_rd,
  .o_io_claim, .i_char_tick, .i_hpos, .i_hsync, .i_vsync, .i_last_line,
  .i_odd_frame, .i_active, .i_blank, .i_equ_window, .o_interlace,
  .o_half_vsync, .o_pedestal, .o_blank, .o_serration, .o_equ_pulse
);

`default_nettype wire

/* File: verification/test_interlace_composite_sync_control.sv */
// Random and corner stimulus for the interlace and sync control block
`timescale 1ns/10ps
`default_nettype none
`include "icsc_regs.svh"

module test_interlace_composite_sync_control;
  logic        i_mclk, i_nrst, i_color_sel, i_io_wr, i_io_rd, i_csync;
  logic [15:0] i_io_addr;
  logic [7:0]  i_io_wdata, o_io_rdata, i_hpos, v, w;
  logic        o_io_claim, i_char_tick, i_hsync, i_vsync, i_last_line;
  logic        i_odd_frame, i_active, i_blank, i_equ_window, o_interlace;
  logic        o_pal_sel, o_half_vsync, o_pedestal, o_blank, o_serration;
  logic        o_equ_pulse, o_csync, pa, pb;
  int          miscompares, n_tests, cyc, seed, d, n, k;

  icsc_top u_dut (.i_mclk, .i_nrst, .i_color_sel, .i_io_addr, .i_io_wr,
    .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_claim, .i_char_tick, .i_hpos,
    .i_hsync, .i_vsync, .i_last_line, .i_odd_frame, .i_active, .i_blank,
    .i_equ_window, .i_csync, .o_interlace, .o_pal_sel, .o_half_vsync,
    .o_pedestal, .o_blank, .o_serration, .o_equ_pulse, .o_csync);
  icsc_timing_model u_gen (.i_mclk, .i_nrst, .o_char_tick(i_char_tick),
    .o_hpos(i_hpos), .o_hsync(i_hsync), .o_vsync(i_vsync),
    .o_last_line(i_last_line), .o_odd_frame(i_odd_frame),
    .o_active(i_active), .o_blank(i_blank), .o_equ_window(i_equ_window));

  initial
  begin
    i_mclk = 0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic step(input int c = 1);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask

  // Wait bounded for a level; d holds cycles spent
  task automatic seek(ref logic s, input int lim);
    for (d = 0; d < lim && s !== 1'b1; d++)
      step();
  endtask

  task automatic acc(input logic rd, input logic [15:0] a,
                     input logic [7:0] wd, input logic cl);
    step();
    i_io_addr = a;
    i_io_wdata = wd;
    i_io_rd = rd;
    i_io_wr = !rd;
    #1 chk(o_io_claim, cl);
    step();
    i_io_rd = 0;
    i_io_wr = 0;
  endtask

  function automatic logic [15:0] port(input logic dp);
    return (i_color_sel ? `ICSC_PORT_COLOR_IDX : `ICSC_PORT_MONO_IDX) + dp;
  endfunction

  task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
    acc(0, port(0), idx, 1);
    acc(0, port(1), val, 1);
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [7:0] e);
    acc(0, port(0), idx, 1);
    acc(1, port(1), 8'h00, 1);
    chk(o_io_rdata, e);
  endtask

  initial
  begin
    seed = 32'h20d4;
    {i_nrst, i_color_sel, i_io_wr, i_io_rd, i_csync} = '0;
    i_io_addr = '0;
    i_io_wdata = '0;
    step(3);
    i_nrst = 1;
    step(3);
    chk({o_interlace, o_pal_sel}, 0);
    for (k = 0; k < 12; k++)
    begin
      i_color_sel = k > 5;
      n = 8'h70 + k % 6;
      if (k < 6)
        rreg(n, 8'h00);
      v = $random(seed);
      wreg(n, v);
      rreg(n, n > 8'h74 ? 8'h00 : n == 8'h74 ? v & 8'h3f : v);
    end
    acc(0, `ICSC_PORT_MONO_IDX, 8'h70, 0);
    acc(1, port(0), 8'h00, 1);
    chk(o_io_rdata, 8'h75);
    wreg(8'h70, 8'h00);
    seek(o_half_vsync, 16400);
    chk(d, 16400);
    v = {1'b0, 7'($random(seed))} % 8'd127;
    wreg(8'h70, 8'h80 | v);
    chk(o_interlace, 1);
    seek(o_half_vsync, 16400);
    chk({i_odd_frame, i_last_line, i_hpos}, {2'b11, v + 8'd1});
    wreg(8'h70, 8'h00);
    for (n = 0; n < 2; n++)
    begin
      v = n ? 8'h00 : 8'hc0;
      wreg(8'h71, v);
      chk(o_pal_sel, v[7]);
      for (k = 0; k < 1100; k++)
      begin
        pa = i_active;
        pb = i_blank;
        step();
        chk({o_pedestal, o_blank}, {pa & v[6], pb});
      end
    end
    // Odd-frame blanking only follows its input at the half-line point
    v = {1'b0, 7'($random(seed))};
    wreg(8'h70, 8'h80 | v);
    wreg(8'h71, 8'h20);
    seek(i_odd_frame, 8200);
    pb = o_blank;
    for (k = 0; k < 1100; k++)
    begin
      if (!i_odd_frame || (i_hpos == v && i_char_tick))
        pb = i_blank;
      step();
      chk(o_blank, pb);
    end
    v = 8'($random(seed)) & 8'h3f;
    wreg(8'h72, v);
    w = 8'h40 | (8'($random(seed)) & 8'h3e);
    wreg(8'h73, w);
    n = 0;
    for (k = 0; k < 8192; k++)
    begin
      step();
      if (o_serration === 1'b1)
      begin
        n++;
        pa = i_hpos == 8'(v + 1) || i_hpos == 8'(w + 1);
        chk(i_vsync && pa, 1);
      end
    end
    chk(n, 4);
    for (k = 0; k < 4; k++)
    begin
      // Corners zero and full width, then random, then suppressed
      v = {2'b11, k == 3, k == 0 ? 5'h00 : k == 1 ? 5'h1f : 5'($random(seed))};
      wreg(8'h74, v);
      // A pulse begun before the write keeps its old width; let it end
      for (n = 0; o_equ_pulse === 1'b1 && n < 40; n++)
        step();
      seek(o_equ_pulse, 8300);
      for (n = 0; o_equ_pulse === 1'b1 && n < 40; n++)
        step();
      chk(n, k == 3 ? 0 : (v[4:0] >> 1) + 1);
    end
    for (k = 0; k < 8; k++)
    begin
      v = {3'b000, k < 4 ? 2'b00 : 2'($random(seed)), 3'(k)};
      wreg(8'h71, v);
      i_csync = 1;
      seek(o_csync, 40);
      n = v[2:0] + 4 * v[4:3];
      chk(v[4:3] == 0 ? d == n + 1 : d >= n - 2 && d <= n + 1, 1);
      i_csync = 0;
      step(40);
    end
    stop_test();
  end
endmodule

`default_nettype wire
